// File: include/sgx_pkg.sv
// Constants and carrier types of the serial GPIO expander core
package sgx_pkg;
  localparam int NPIN   = 22;
  localparam int DRVW   = 2 * NPIN;
  localparam int SHW    = 24;
  localparam int BANK_W = 8;
  // APB byte offsets
  localparam logic [7:0] OFS_INPUT    = 8'h00;
  localparam logic [7:0] OFS_OUTPUT   = 8'h04;
  localparam logic [7:0] OFS_POLARITY = 8'h08;
  localparam logic [7:0] OFS_DIR      = 8'h0C;
  localparam logic [7:0] OFS_DRIVE_LO = 8'h10;
  localparam logic [7:0] OFS_DRIVE_HI = 8'h14;
  localparam logic [7:0] OFS_LATCH    = 8'h18;
  localparam logic [7:0] OFS_PULL_EN  = 8'h1C;
  localparam logic [7:0] OFS_PULL_SEL = 8'h20;
  localparam logic [7:0] OFS_MASK     = 8'h24;
  localparam logic [7:0] OFS_STATUS   = 8'h28;
  localparam logic [7:0] OFS_OD_BANK  = 8'h2C;
  localparam logic [7:0] OFS_OD_PIN   = 8'h30;
  localparam logic [7:0] OFS_EDGE_R   = 8'h34;
  localparam logic [7:0] OFS_EDGE_F   = 8'h38;
  localparam logic [7:0] OFS_CLEAR    = 8'h3C;
  localparam logic [7:0] OFS_DEB_EN   = 8'h40;
  localparam logic [7:0] OFS_LINK     = 8'h44;
  // Values after reset
  localparam logic [NPIN-1:0] RST_DIR   = 22'h3FFFFF;
  localparam logic [NPIN-1:0] RST_MASK  = 22'h3FFFFF;
  localparam logic [DRVW-1:0] RST_DRIVE = 44'hFFFFFFFFFFF;
  // Link framing
  localparam logic [5:0] SPI_BASE_ADDR = 6'h20;
  localparam logic [4:0] SPI_ADDR_LAST = 5'h07;
  localparam logic [4:0] SPI_DATA_LAST = 5'h17;
  // Timing
  localparam int CLK_MHZ     = 125;
  localparam int DEB_TIME_US = 1000;
  localparam int DEB_CYCLES  = DEB_TIME_US * CLK_MHZ;
  localparam int DEB_CNTW    = 17;

  typedef enum logic [4:0] {
    SPI_IDLE  = 5'h01,
    SPI_ADDR  = 5'h02,
    SPI_READ  = 5'h04,
    SPI_WRITE = 5'h08,
    SPI_SKIP  = 5'h10
  } sgx_spi_e;

  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic serial_in;
  } sgx_spi_s;

  typedef struct packed {
    logic [NPIN-1:0] out;
    logic [NPIN-1:0] oe;
    logic [NPIN-1:0] pull_en;
    logic [NPIN-1:0] pull_up;
    logic [DRVW-1:0] drive;
  } sgx_pad_s;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } sgx_apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } sgx_apb_rsp_s;
endpackage : sgx_pkg

// File: verilog/sgx_core.sv
// Serial GPIO expander core: port registers, alert, debounce, link and APB slave
`timescale 1ns/1ps
// Overview of operation
// - 22 pins, each configurable, one slave link
// - All pins are inputs after reset
// - Direction bits set each pin in or out
// - Separate input and output port registers
// - Polarity bit inverts reported input value
// - Reset pin restores defaults and link state
// - Alert pulled low on unserviced input change
// - Per-pin choice of level or edge alert
// - Mask bit blocks a pin's alert
// - Latched input held until port read
// - Read-only status names alerting pins
// - Pending events cleared per pin; an input read clears all
// - Status read never clears events
// - Push-pull or open-drain, per bank or pin
// - Four drive strength levels per pin
// - Pull enable and pull-up/down select per pin
// - Debounce filters switch contact bounce
// - Strap picks one of two link addresses
// - Link clock up to 5 MHz supported
module sgx_core #(
  parameter int DEB_CYCLES = sgx_pkg::DEB_CYCLES
) (
  input  wire logic                     clk_sys,
  input  wire logic                     srst,
  input  wire logic                     rst_pin_n,
  input  wire logic                     addr_strap,
  input  wire sgx_pkg::sgx_spi_s        spi,
  output logic                          serial_out,
  input  wire logic [sgx_pkg::NPIN-1:0] gpio_in,
  output sgx_pkg::sgx_pad_s             pads,
  input  wire logic                     alert_in,
  output logic                          alert_out,
  output logic                          alert_oe,
  input  wire sgx_pkg::sgx_apb_req_s    apb_req,
  output sgx_pkg::sgx_apb_rsp_s         apb_rsp
);
  localparam int NPIN = sgx_pkg::NPIN;
  localparam int DRVW = sgx_pkg::DRVW;
  localparam int SHW  = sgx_pkg::SHW;
  localparam int DCW  = sgx_pkg::DEB_CNTW;

  typedef struct packed {
    logic [1:0]            rstn_sy;
    logic [NPIN-1:0]       pin_s1;
    logic [NPIN-1:0]       pin_s2;
    sgx_pkg::sgx_spi_s     spi_s1;
    sgx_pkg::sgx_spi_s     spi_s2;
    logic                  sclk_d;
    logic                  cs_d;
    logic [1:0]            strap_sy;
    logic [1:0]            alert_sy;
    logic                  strap;
    logic [NPIN-1:0]       outp;
    logic [NPIN-1:0]       pol;
    logic [NPIN-1:0]       dir;
    logic [DRVW-1:0]       drive;
    logic [NPIN-1:0]       latch_en;
    logic [NPIN-1:0]       pull_en;
    logic [NPIN-1:0]       pull_sel;
    logic [NPIN-1:0]       mask;
    logic [NPIN-1:0]       stat;
    logic [2:0]            od_bank;
    logic [NPIN-1:0]       od_pin;
    logic [NPIN-1:0]       rise;
    logic [NPIN-1:0]       fall;
    logic [NPIN-1:0]       deb_en;
    logic [NPIN-1:0]       live_prev;
    logic [NPIN-1:0]       snap;
    logic [NPIN-1:0]       lat;
    logic [NPIN-1:0]       held;
    logic [NPIN-1:0]       deb_cand;
    logic [NPIN-1:0]       deb_val;
    logic [DCW-1:0]        deb_cnt;
    sgx_pkg::sgx_spi_e     spi_st;
    logic [4:0]            bitc;
    logic [SHW-1:0]        sh_in;
    logic [SHW-1:0]        sh_out;
    logic [7:0]            frames;
    logic                  sdo;
    sgx_pkg::sgx_pad_s     pad;
    logic                  alert_oe;
    logic                  alert_low;
    sgx_pkg::sgx_apb_rsp_s rsp;
  } sgx_state_s;

  sgx_state_s      st;
  sgx_state_s      next_st;
  logic [NPIN-1:0] od;
  logic [NPIN-1:0] live;
  logic [NPIN-1:0] reported;
  logic [NPIN-1:0] edge_mode;
  logic [NPIN-1:0] edge_ev;
  logic [NPIN-1:0] lvl_ev;
  logic [NPIN-1:0] ev;
  logic [NPIN-1:0] wr_clr_mask;
  logic [NPIN-1:0] auto_clr;
  logic [NPIN-1:0] clr_vec;
  logic [NPIN-1:0] held_lat;
  logic [NPIN-1:0] agree;
  logic [SHW-1:0]  sh_next;
  logic [7:0]      addr_byte;
  logic            addr_hit;
  logic            sclk_rise;
  logic            sclk_fall;
  logic            cs_fall;
  logic            setup;
  logic            acc;
  logic            wr;
  logic            rd_in;
  logic            rd_spi;
  logic            rd_clr;
  logic            deb_tick;
  logic            any_pend;
  logic [31:0]     rd_data;
  logic            rd_ok;

  // Defaults; synchronisers and the bus answer survive a pin reset
  function automatic sgx_state_s sgx_init(input sgx_state_s cur);
    sgx_state_s s;
    s = '0;
    s.rstn_sy = cur.rstn_sy;
    s.pin_s1 = cur.pin_s1;
    s.pin_s2 = cur.pin_s2;
    s.spi_s1 = cur.spi_s1;
    s.spi_s2 = cur.spi_s2;
    s.sclk_d = cur.sclk_d;
    s.cs_d = cur.cs_d;
    s.strap_sy = cur.strap_sy;
    s.alert_sy = cur.alert_sy;
    s.strap = cur.strap_sy[1];
    s.rsp = cur.rsp;
    s.dir = sgx_pkg::RST_DIR;
    s.mask = sgx_pkg::RST_MASK;
    s.drive = sgx_pkg::RST_DRIVE;
    s.pad.drive = sgx_pkg::RST_DRIVE;
    s.spi_st = sgx_pkg::SPI_IDLE;
    return s;
  endfunction : sgx_init

  function automatic logic sgx_hit(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction : sgx_hit

  for (genvar i = 0; i < NPIN; i++) begin : g_od
    assign od[i] = st.od_bank[i / sgx_pkg::BANK_W] | st.od_pin[i];
  end

  // Sampling at 125 MHz leaves over 12 cycles per half period of a 5 MHz link
  assign sclk_rise = st.spi_s2.sclk & ~st.sclk_d;
  assign sclk_fall = ~st.spi_s2.sclk & st.sclk_d;
  assign cs_fall   = ~st.spi_s2.cs_n & st.cs_d;
  assign setup     = apb_req.psel & ~apb_req.penable;
  assign acc       = apb_req.psel & apb_req.penable & st.rsp.pready;
  assign wr        = acc & apb_req.pwrite;
  assign rd_in     = acc & ~apb_req.pwrite & sgx_hit(apb_req.paddr, sgx_pkg::OFS_INPUT);
  assign sh_next   = {st.sh_in[SHW-2:0], st.spi_s2.serial_in};
  assign addr_byte = sh_next[7:0];
  assign addr_hit  = addr_byte[7:1] == {sgx_pkg::SPI_BASE_ADDR, st.strap};
  assign rd_spi    = (st.spi_st == sgx_pkg::SPI_ADDR) & sclk_rise
                   & (st.bitc == sgx_pkg::SPI_ADDR_LAST) & addr_hit & addr_byte[0];
  assign rd_clr    = rd_in | rd_spi;
  assign deb_tick  = st.deb_cnt == DCW'(DEB_CYCLES - 1);
  assign agree     = ~(st.pin_s2 ^ st.deb_cand);
  assign live      = (st.deb_en & st.deb_val) | (~st.deb_en & st.pin_s2);
  assign held_lat  = st.held & st.latch_en;
  assign reported  = ((held_lat & st.lat) | (~held_lat & live)) ^ st.pol;
  assign edge_mode = st.rise | st.fall;
  assign edge_ev   = (st.rise & live & ~st.live_prev) | (st.fall & ~live & st.live_prev);
  // A read re-bases the compare value, so no level event in that cycle
  assign lvl_ev    = rd_clr ? '0 : (live ^ st.snap);
  assign ev        = ~st.mask & ((edge_mode & edge_ev) | (~edge_mode & lvl_ev));
  assign wr_clr_mask = (wr && sgx_hit(apb_req.paddr, sgx_pkg::OFS_CLEAR))
                     ? apb_req.pwdata[NPIN-1:0] : '0;
  assign auto_clr  = ~edge_mode & ~st.latch_en & ~(live ^ st.snap);
  assign clr_vec   = {NPIN{rd_clr}} | wr_clr_mask | auto_clr;
  assign any_pend  = |st.stat;

  always_comb begin
    next_st = st;
    rd_data = '0;
    rd_ok = 1'b1;
    next_st.rstn_sy = {st.rstn_sy[0], rst_pin_n};
    next_st.pin_s1 = gpio_in;
    next_st.pin_s2 = st.pin_s1;
    next_st.spi_s1 = spi;
    next_st.spi_s2 = st.spi_s1;
    next_st.strap_sy = {st.strap_sy[0], addr_strap};
    next_st.alert_sy = {st.alert_sy[0], alert_in};
    next_st.sclk_d = st.spi_s2.sclk;
    next_st.cs_d = st.spi_s2.cs_n;

    // Register read, answered one cycle after the setup cycle
    case (apb_req.paddr)
      sgx_pkg::OFS_INPUT:    rd_data[NPIN-1:0] = reported;
      sgx_pkg::OFS_OUTPUT:   rd_data[NPIN-1:0] = st.outp;
      sgx_pkg::OFS_POLARITY: rd_data[NPIN-1:0] = st.pol;
      sgx_pkg::OFS_DIR:      rd_data[NPIN-1:0] = st.dir;
      sgx_pkg::OFS_DRIVE_LO: rd_data = st.drive[31:0];
      sgx_pkg::OFS_DRIVE_HI: rd_data[DRVW-33:0] = st.drive[DRVW-1:32];
      sgx_pkg::OFS_LATCH:    rd_data[NPIN-1:0] = st.latch_en;
      sgx_pkg::OFS_PULL_EN:  rd_data[NPIN-1:0] = st.pull_en;
      sgx_pkg::OFS_PULL_SEL: rd_data[NPIN-1:0] = st.pull_sel;
      sgx_pkg::OFS_MASK:     rd_data[NPIN-1:0] = st.mask;
      sgx_pkg::OFS_STATUS:   rd_data[NPIN-1:0] = st.stat;
      sgx_pkg::OFS_OD_BANK:  rd_data[2:0] = st.od_bank;
      sgx_pkg::OFS_OD_PIN:   rd_data[NPIN-1:0] = st.od_pin;
      sgx_pkg::OFS_EDGE_R:   rd_data[NPIN-1:0] = st.rise;
      sgx_pkg::OFS_EDGE_F:   rd_data[NPIN-1:0] = st.fall;
      sgx_pkg::OFS_CLEAR:    rd_data = '0;
      sgx_pkg::OFS_DEB_EN:   rd_data[NPIN-1:0] = st.deb_en;
      sgx_pkg::OFS_LINK:     rd_data[15:0] = {st.frames, 6'h00, st.alert_sy[1], st.strap};
      default:               rd_ok = 1'b0;
    endcase
    next_st.rsp.pready = setup;
    next_st.rsp.prdata = setup ? rd_data : '0;
    next_st.rsp.pslverr = setup & ~rd_ok;

    if (wr) begin
      case (apb_req.paddr)
        sgx_pkg::OFS_OUTPUT:   next_st.outp = apb_req.pwdata[NPIN-1:0];
        sgx_pkg::OFS_POLARITY: next_st.pol = apb_req.pwdata[NPIN-1:0];
        sgx_pkg::OFS_DIR:      next_st.dir = apb_req.pwdata[NPIN-1:0];
        sgx_pkg::OFS_DRIVE_LO: next_st.drive[31:0] = apb_req.pwdata;
        sgx_pkg::OFS_DRIVE_HI: next_st.drive[DRVW-1:32] = apb_req.pwdata[DRVW-33:0];
        sgx_pkg::OFS_LATCH:    next_st.latch_en = apb_req.pwdata[NPIN-1:0];
        sgx_pkg::OFS_PULL_EN:  next_st.pull_en = apb_req.pwdata[NPIN-1:0];
        sgx_pkg::OFS_PULL_SEL: next_st.pull_sel = apb_req.pwdata[NPIN-1:0];
        sgx_pkg::OFS_MASK:     next_st.mask = apb_req.pwdata[NPIN-1:0];
        sgx_pkg::OFS_OD_BANK:  next_st.od_bank = apb_req.pwdata[2:0];
        sgx_pkg::OFS_OD_PIN:   next_st.od_pin = apb_req.pwdata[NPIN-1:0];
        sgx_pkg::OFS_EDGE_R:   next_st.rise = apb_req.pwdata[NPIN-1:0];
        sgx_pkg::OFS_EDGE_F:   next_st.fall = apb_req.pwdata[NPIN-1:0];
        sgx_pkg::OFS_DEB_EN:   next_st.deb_en = apb_req.pwdata[NPIN-1:0];
        default:               ;
      endcase
    end

    // Two agreeing samples one tick apart; a shared tick saves 21 counters
    next_st.deb_cnt = deb_tick ? '0 : st.deb_cnt + 1'b1;
    if (deb_tick) begin
      next_st.deb_cand = st.pin_s2;
      next_st.deb_val = (st.deb_val & ~agree) | (st.pin_s2 & agree);
    end

    // Pending events: a set in the clearing cycle wins
    next_st.live_prev = live;
    next_st.stat = (st.stat & ~clr_vec) | ev;
    next_st.held = rd_clr ? '0 : (st.held | (st.latch_en & (live ^ st.snap)));
    next_st.lat = (st.held & st.lat) | (~st.held & live);
    if (rd_clr) begin
      next_st.snap = live;
    end

    next_st.pad.out = st.outp;
    next_st.pad.oe = ~st.dir & (~od | ~st.outp);
    next_st.pad.pull_en = st.pull_en;
    next_st.pad.pull_up = st.pull_sel;
    next_st.pad.drive = st.drive;
    next_st.alert_oe = any_pend;
    next_st.alert_low = 1'b0;

    // Link: address byte, then 24 bits out or in, mode 0
    case (st.spi_st)
      sgx_pkg::SPI_IDLE: begin
        if (cs_fall) begin
          next_st.spi_st = sgx_pkg::SPI_ADDR;
          next_st.bitc = '0;
        end
      end
      sgx_pkg::SPI_ADDR: begin
        if (sclk_rise) begin
          next_st.sh_in = sh_next;
          next_st.bitc = st.bitc + 1'b1;
          if (st.bitc == sgx_pkg::SPI_ADDR_LAST) begin
            next_st.bitc = '0;
            if (addr_hit) begin
              next_st.frames = st.frames + 1'b1;
              next_st.spi_st = addr_byte[0] ? sgx_pkg::SPI_READ : sgx_pkg::SPI_WRITE;
              next_st.sh_out = {2'h0, reported};
            end else begin
              next_st.spi_st = sgx_pkg::SPI_SKIP;
            end
          end
        end
      end
      sgx_pkg::SPI_READ: begin
        if (sclk_fall) begin
          next_st.sdo = st.sh_out[SHW-1];
          next_st.sh_out = {st.sh_out[SHW-2:0], 1'b0};
        end
      end
      sgx_pkg::SPI_WRITE: begin
        if (sclk_rise) begin
          next_st.sh_in = sh_next;
          next_st.bitc = st.bitc + 1'b1;
          if (st.bitc == sgx_pkg::SPI_DATA_LAST) begin
            next_st.outp = sh_next[NPIN-1:0];
            next_st.spi_st = sgx_pkg::SPI_SKIP;
          end
        end
      end
      sgx_pkg::SPI_SKIP: ;
      default: next_st.spi_st = sgx_pkg::SPI_IDLE;
    endcase
    if (st.spi_s2.cs_n) begin
      next_st.spi_st = sgx_pkg::SPI_IDLE;
      next_st.sdo = 1'b0;
    end

    if (~st.rstn_sy[1]) begin
      next_st = sgx_init(next_st);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st <= sgx_init('0);
    end else begin
      st <= next_st;
    end
  end

  assign serial_out = st.sdo;
  assign pads       = st.pad;
  assign alert_oe   = st.alert_oe;
  assign alert_out  = st.alert_low;
  assign apb_rsp    = st.rsp;

  default clocking sgx_cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);

  dir_reset_a: assert property (~st.rstn_sy[1] |=> st.dir == sgx_pkg::RST_DIR)
    else $error("Pins not all inputs after reset");
  reset_clear_a: assert property (~st.rstn_sy[1] |=>
    st.stat == '0 && st.spi_st == sgx_pkg::SPI_IDLE && st.outp == '0)
    else $error("Pin reset left state behind");
  input_undriven_a: assert property (st.rstn_sy[1] |=> (st.pad.oe & $past(st.dir)) == '0)
    else $error("Input pin driven");
  input_read_a: assert property (st.rstn_sy[1] && setup &&
    apb_req.paddr == sgx_pkg::OFS_INPUT |=> apb_rsp.prdata[NPIN-1:0] == $past(reported))
    else $error("Input port read value wrong");
  mask_block_a: assert property (st.rstn_sy[1] |=>
    (st.stat & ~$past(st.stat) & $past(st.mask)) == '0)
    else $error("Masked pin raised an event");
  alert_follow_a: assert property (st.rstn_sy[1] |=> st.alert_oe == $past(any_pend))
    else $error("Alert does not follow pending events");
  keep_pending_a: assert property (st.rstn_sy[1] |=>
    ($past(st.stat) & ~$past(clr_vec) & ~st.stat) == '0)
    else $error("Pending event lost without a clear");
  latch_hold_a: assert property (st.rstn_sy[1] |=>
    ($past(held_lat) & (st.lat ^ $past(st.lat))) == '0)
    else $error("Latched input changed while held");
  read_release_a: assert property (st.rstn_sy[1] && rd_clr |=> st.held == '0)
    else $error("Input read did not release latch");
  deb_stable_a: assert property (st.rstn_sy[1] && !deb_tick |=>
    st.deb_val == $past(st.deb_val))
    else $error("Debounced value moved between ticks");
  apb_wait_a: assert property (setup |=> apb_rsp.pready ##1 !apb_rsp.pready)
    else $error("APB answer not one cycle after setup");
endmodule : sgx_core

// File: tb/sgx_spi_master.sv
// Link master model driving frames into the expander core
`timescale 1ns/1ps
module sgx_spi_master #(
  parameter realtime HALF_NS = 125.0
) (
  output sgx_pkg::sgx_spi_s spi,
  input  wire logic         serial_out
);
  // Clock stands low between frames; data idles inverted, nothing settles it
  initial begin
    spi = '{sclk: 1'b0, cs_n: 1'b1, serial_in: 1'b1};
  end

  // Half period held at the 5 MHz ceiling or slower
  task automatic frame(input logic [7:0] hdr, input logic [23:0] wd, output logic [23:0] rd);
    logic [31:0] sh;
    sh = {hdr, wd};
    rd = '0;
    spi.cs_n = 1'b0;
    #(HALF_NS);
    for (int i = 31; i >= 0; i--) begin
      spi.serial_in = sh[i];
      #(HALF_NS);
      spi.sclk = 1'b1;
      if (i < 24) rd[i] = serial_out;
      #(HALF_NS);
      spi.sclk = 1'b0;
    end
    spi.cs_n = 1'b1;
    spi.serial_in = ~spi.serial_in;
    #(4 * HALF_NS);
  endtask : frame
endmodule : sgx_spi_master

// File: tb/tb_top.sv
// Self-checking bench of the serial GPIO expander core
`timescale 1ns/1ps
module tb_top;
  logic                     clk_sys;
  logic                     srst;
  logic                     rst_pin_n;
  logic                     addr_strap;
  sgx_pkg::sgx_spi_s        spi;
  logic                     serial_out;
  logic [sgx_pkg::NPIN-1:0] gpio_in;
  sgx_pkg::sgx_pad_s        pads;
  logic                     alert_wire;
  logic                     alert_out;
  logic                     alert_oe;
  sgx_pkg::sgx_apb_req_s    apb_req;
  sgx_pkg::sgx_apb_rsp_s    apb_rsp;
  int                       miscompares;
  int                       num_checks;
  int                       seed;
  logic [31:0]              rd;
  logic                     err;
  logic [31:0]              v0, v1, v2, v3;
  logic [23:0]              srd;

  // Pull-up on the shared alert wire
  assign alert_wire = alert_oe ? alert_out : 1'b1;

  sgx_core #(.DEB_CYCLES(8)) u_sgx_core (
    .clk_sys(clk_sys), .srst(srst), .rst_pin_n(rst_pin_n), .addr_strap(addr_strap),
    .spi(spi), .serial_out(serial_out), .gpio_in(gpio_in), .pads(pads),
    .alert_in(alert_wire), .alert_out(alert_out), .alert_oe(alert_oe),
    .apb_req(apb_req), .apb_rsp(apb_rsp)
  );

  sgx_spi_master u_sgx_spi_master (.spi(spi), .serial_out(serial_out));

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  function automatic logic [21:0] exp_oe(logic [31:0] d, logic [31:0] o, logic [31:0] p,
                                         logic [2:0] b);
    logic [21:0] odm;
    odm = p[21:0];
    for (int i = 0; i < 22; i++) if (b[i/8]) odm[i] = 1'b1;
    return ~d[21:0] & (~odm | ~o[21:0]);
  endfunction : exp_oe

  task automatic check(input string nm, input logic [63:0] exp, input logic [63:0] got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : check

  task automatic report_and_stop;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop

  // Entered just after a rising edge, leaves just after one
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] q, output logic e);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
    @(posedge clk_sys);
    apb_req.penable <= 1'b1;
    // Only the watchdog ends a wait that never sees pready
    do begin
      @(posedge clk_sys);
    end while (apb_rsp.pready !== 1'b1);
    q = apb_rsp.prdata;
    e = apb_rsp.pslverr;
    apb_req <= '0;
    @(posedge clk_sys);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask : wr

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string nm);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    check(nm, 64'(exp), 64'(q));
  endtask : rchk

  task automatic wait_alert(input logic v);
    for (int n = 0; n < 40 && alert_oe !== v; n++) @(posedge clk_sys);
  endtask : wait_alert

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : tick

  initial begin
    #500000;
    miscompares++;
    report_and_stop;
  end

  initial begin
    seed = 32'h170E;
    miscompares = 0;
    num_checks = 0;
    srst = 1'b1;
    rst_pin_n = 1'b1;
    addr_strap = 1'b0;
    gpio_in = '0;
    apb_req = '0;
    tick(16);
    srst <= 1'b0;
    tick(8);
    check("oe_rst", 64'h0, 64'(pads.oe));
    check("drive_rst", 64'(sgx_pkg::RST_DRIVE), 64'(pads.drive));
    rchk(sgx_pkg::OFS_DIR, 32'(sgx_pkg::RST_DIR), "dir_rst");
    rchk(sgx_pkg::OFS_MASK, 32'(sgx_pkg::RST_MASK), "mask_rst");
    apb(1'b0, 8'h80, 32'h0, rd, err);
    check("slverr", 64'h1, 64'(err));
    check("unmapped", 64'h0, 64'(rd));
    for (int k = 0; k < 8; k++) begin
      v0 = $random(seed);
      v1 = $random(seed);
      v2 = $random(seed);
      wr(sgx_pkg::OFS_DIR, v0);
      wr(sgx_pkg::OFS_OUTPUT, v1);
      wr(sgx_pkg::OFS_OD_PIN, v2);
      wr(sgx_pkg::OFS_OD_BANK, 32'(k));
      tick(3);
      check("pad_out", 64'(v1[21:0]), 64'(pads.out));
      check("pad_oe", 64'(exp_oe(v0, v1, v2, 3'(k))), 64'(pads.oe));
      rchk(sgx_pkg::OFS_DIR, v0 & 32'h3FFFFF, "dir_reg");
    end
    wr(sgx_pkg::OFS_DIR, 32'h3FFFFF);
    v0 = $random(seed);
    v1 = $random(seed);
    v2 = $random(seed);
    v3 = $random(seed);
    wr(sgx_pkg::OFS_DRIVE_LO, v0);
    wr(sgx_pkg::OFS_DRIVE_HI, v1);
    wr(sgx_pkg::OFS_PULL_EN, v2);
    wr(sgx_pkg::OFS_PULL_SEL, v3);
    tick(3);
    check("drive", 64'({v1[11:0], v0}), 64'(pads.drive));
    check("pull_en", 64'(v2[21:0]), 64'(pads.pull_en));
    check("pull_up", 64'(v3[21:0]), 64'(pads.pull_up));
    for (int k = 0; k < 4; k++) begin
      v0 = $random(seed);
      v1 = $random(seed);
      wr(sgx_pkg::OFS_POLARITY, v1);
      gpio_in <= v0[21:0];
      tick(6);
      rchk(sgx_pkg::OFS_INPUT, (v0 ^ v1) & 32'h3FFFFF, "input_pol");
    end
    wr(sgx_pkg::OFS_POLARITY, 32'h0);
    gpio_in <= '0;
    tick(6);
    rchk(sgx_pkg::OFS_INPUT, 32'h0, "input_zero");
    wr(sgx_pkg::OFS_EDGE_R, 32'h3);
    wr(sgx_pkg::OFS_MASK, 32'h3FFFFC);
    gpio_in <= 22'h7;
    wait_alert(1'b1);
    check("alert_set", 64'h1, 64'(alert_oe));
    rchk(sgx_pkg::OFS_STATUS, 32'h3, "status");
    rchk(sgx_pkg::OFS_STATUS, 32'h3, "status_again");
    apb(1'b0, sgx_pkg::OFS_LINK, 32'h0, rd, err);
    check("alert_wire", 64'h0, 64'(rd[1]));
    wr(sgx_pkg::OFS_CLEAR, 32'h1);
    rchk(sgx_pkg::OFS_STATUS, 32'h2, "status_clr");
    check("alert_hold", 64'h1, 64'(alert_oe));
    rchk(sgx_pkg::OFS_INPUT, 32'h7, "input_evt");
    tick(4);
    check("alert_rel", 64'h0, 64'(alert_oe));
    gpio_in <= '0;
    tick(12);
    check("no_fall_alert", 64'h0, 64'(alert_oe));
    rchk(sgx_pkg::OFS_STATUS, 32'h0, "status_fall");
    rchk(sgx_pkg::OFS_INPUT, 32'h0, "input_base");
    wr(sgx_pkg::OFS_EDGE_R, 32'h1);
    wr(sgx_pkg::OFS_EDGE_F, 32'h2);
    gpio_in <= 22'h3;
    tick(12);
    rchk(sgx_pkg::OFS_STATUS, 32'h1, "rise_edge");
    wr(sgx_pkg::OFS_CLEAR, 32'h1);
    gpio_in <= '0;
    tick(12);
    rchk(sgx_pkg::OFS_STATUS, 32'h2, "fall_edge");
    rchk(sgx_pkg::OFS_INPUT, 32'h0, "input_idle");
    wr(sgx_pkg::OFS_EDGE_R, 32'h0);
    wr(sgx_pkg::OFS_LATCH, 32'h8);
    wr(sgx_pkg::OFS_MASK, 32'h3FFFF7);
    gpio_in <= 22'h8;
    tick(10);
    gpio_in <= '0;
    wait_alert(1'b1);
    check("alert_lvl", 64'h1, 64'(alert_oe));
    tick(10);
    rchk(sgx_pkg::OFS_INPUT, 32'h8, "latched");
    rchk(sgx_pkg::OFS_INPUT, 32'h0, "unlatched");
    wr(sgx_pkg::OFS_MASK, 32'h3FFFFF);
    wr(sgx_pkg::OFS_DEB_EN, 32'h10);
    gpio_in <= 22'h10;
    @(posedge clk_sys);
    gpio_in <= '0;
    tick(40);
    rchk(sgx_pkg::OFS_INPUT, 32'h0, "bounce");
    gpio_in <= 22'h10;
    tick(60);
    rchk(sgx_pkg::OFS_INPUT, 32'h10, "debounced");
    v0 = $random(seed);
    v1 = $random(seed);
    gpio_in <= v0[21:0];
    tick(60);
    u_sgx_spi_master.frame({sgx_pkg::SPI_BASE_ADDR, 2'b01}, 24'h0, srd);
    check("spi_read", 64'({2'b00, v0[21:0]}), 64'(srd));
    u_sgx_spi_master.frame({sgx_pkg::SPI_BASE_ADDR, 2'b11}, 24'h0, srd);
    check("spi_other", 64'h0, 64'(srd));
    u_sgx_spi_master.frame({sgx_pkg::SPI_BASE_ADDR, 2'b00}, v1[23:0], srd);
    @(posedge clk_sys);
    rchk(sgx_pkg::OFS_OUTPUT, v1 & 32'h3FFFFF, "spi_write");
    wr(sgx_pkg::OFS_DIR, 32'h0);
    addr_strap <= 1'b1;
    rst_pin_n <= 1'b0;
    tick(6);
    check("oe_pinrst", 64'h0, 64'(pads.oe));
    rst_pin_n <= 1'b1;
    tick(8);
    rchk(sgx_pkg::OFS_DIR, 32'(sgx_pkg::RST_DIR), "dir_pinrst");
    apb(1'b0, sgx_pkg::OFS_LINK, 32'h0, rd, err);
    check("strap", 64'h1, 64'(rd[0]));
    check("alert_idle", 64'h1, 64'(rd[1]));
    check("frames_rst", 64'h0, 64'(rd[15:8]));
    u_sgx_spi_master.frame({sgx_pkg::SPI_BASE_ADDR, 2'b10}, 24'h15A5A5, srd);
    @(posedge clk_sys);
    rchk(sgx_pkg::OFS_OUTPUT, 32'h15A5A5, "strap_write");
    report_and_stop;
  end
endmodule : tb_top
